// ==== src/period_match_timer_consts.svh ====
// Purpose: Constants for the period-match timer
// Assumes: Included by the package and the timer module
// Notes:   Register offsets are word indices on the plain register port
`ifndef PERIOD_MATCH_TIMER_CONSTS_SVH
`define PERIOD_MATCH_TIMER_CONSTS_SVH

`define OFS_TIMER_COUNT    3'h0
`define OFS_PERIOD         3'h1
`define OFS_CONTROL        3'h2
`define OFS_CLOCK_SELECT   3'h3
`define OFS_RESET_SOURCE   3'h4
`define OFS_LIMIT          3'h5
`define OFS_IRQ_STATUS     3'h6
`define OFS_IRQ_MASK       3'h7

`define PERIOD_RESET       8'hFF
`define COUNT_RESET        8'h00
`define CTRL_RESET         8'h00
`define BYTE_ZERO          8'h00

`define CTRL_RUN_BIT       7
`define CTRL_PRESC_LSB     4
`define CTRL_POSTS_LSB     0
`define LIMIT_MODE_LSB     0
`define RSRC_SEL_LSB       0

`define PRESC_W            3
`define POSTS_W            4
`define MODE_W             5
`define RSRC_W             4
`define CLKSEL_W           3

`define POST_COUNT_ZERO    4'h0
`define PRESC_COUNT_ZERO   8'h00
`define PRESC_COUNT_ONE    8'h01
`define IRQ_BIT_MATCH      0

`endif

// ==== src/period_match_timer_pkg.sv ====
// Purpose: Types for the period-match timer
// Assumes: Constants come from the consts header
// Notes:   Mode codes follow the five-bit mode field
`include "period_match_timer_consts.svh"
`default_nettype none
package period_match_timer_pkg;

    typedef enum logic [1:0] {
        BASE_FREE    = 2'h0,
        BASE_ONESHOT = 2'h1,
        BASE_MONO    = 2'h2
    } base_mode_t;

    typedef enum logic [1:0] {
        EXT_NONE   = 2'h0,
        EXT_GATE   = 2'h1,
        EXT_EDGE   = 2'h2,
        EXT_LEVEL  = 2'h3
    } ext_kind_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] count;
        logic       match;
        logic       tick;
        logic       postscaled;
    } pwm_feed_t;

endpackage
`default_nettype wire

// ==== src/period_match_timer.sv ====
// Purpose: 8-bit period-match timer, prescaler, postscaler, external reset source
// Assumes: Single clock ref_clk at 50 MHz; inputs synchronous to it
// Notes:   Plain register port, read data one cycle after the read strobe
//
// Functional notes
// R1 - Count increments on every prescaled tick
// R2 - Match signals postscaler, count clears next tick
// R3 - Postscaler reaches setting: one-tick pulse, clear; code drops the pulse early once counting stops
// R4 - Gate modes hold count while gate inactive
// R5 - Reset modes clear count on level/edge
// R6 - Reset: count zero, period all ones
// R7 - Count/control write, resets clear pre/postscalers
// R8 - One-shot: match clears run enable, stops
// R9 - One-shot restart resets the postscaler
// R10 - Monostable stops at match, keeps enable
// R11 - Four-bit field selects external source
// R12 - Five-bit mode field selects operating mode
// R13 - Trigger edges spaced six ticks apart
// R14 - Trigger level held three ticks minimum
// R15 - Debug freeze ignores external triggers
// R16 - Pulse and count exported to peripherals
// R17 - Interrupt flag set per pulse, masked
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "period_match_timer_consts.svh"
`default_nettype none
module period_match_timer #(
    parameter int SRC_COUNT = 16
) (
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    input  wire period_match_timer_pkg::reg_req_t regReq,
    output logic [7:0]                       rdData,
    input  wire logic [SRC_COUNT-1:0]        extSources,
    input  wire logic                        debugFreeze,
    output logic                             postscaledPulse,
    output period_match_timer_pkg::pwm_feed_t pwmFeed,
    output logic                             irq
);
    import period_match_timer_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]               countReg;
    logic [7:0]               periodReg;
    logic [7:0]               controlReg;
    logic [`CLKSEL_W-1:0]     clkSelReg;
    logic [`RSRC_W-1:0]       rsrcReg;
    logic [`MODE_W-1:0]       modeReg;
    logic                     statusReg;
    logic                     maskReg;
    logic [7:0]               prescReg;
    logic [`POSTS_W-1:0]      postReg;
    logic                     pulseReg;
    logic                     extSrcReg;
    logic                     extPrevReg;
    logic                     runPrevReg;
    logic                     stoppedReg;

    logic                     wrCount;
    logic                     wrControl;
    logic                     runEnable;
    logic [`PRESC_W-1:0]      prescSel;
    logic [`POSTS_W-1:0]      postSel;
    logic [7:0]               prescLimit;
    logic                     tick;
    logic                     match;
    logic                     extLevel;
    logic                     extRise;
    logic                     gateOpen;
    logic                     extClear;
    logic                     clearScalers;
    logic                     counting;
    logic                     restart;
    logic                     postHit;
    base_mode_t               baseMode;
    ext_kind_t                extKind;

    assign wrCount   = regReq.wr && regReq.addr == `OFS_TIMER_COUNT;
    assign wrControl = regReq.wr && regReq.addr == `OFS_CONTROL;
    assign runEnable = controlReg[`CTRL_RUN_BIT];
    assign prescSel  = controlReg[`CTRL_PRESC_LSB +: `PRESC_W];
    assign postSel   = controlReg[`CTRL_POSTS_LSB +: `POSTS_W];

    // ************************************************************
    // Mode decode
    // ************************************************************
    // Upper two mode bits pick the base mode, low bits the external use
    always_comb begin
        unique case (modeReg[4:3])
            2'h0:    baseMode = BASE_FREE;                         // [R12]
            2'h1:    baseMode = BASE_ONESHOT;
            2'h2:    baseMode = BASE_MONO;
            default: baseMode = BASE_FREE;
        endcase
        unique case (modeReg[1:0])
            2'h0:    extKind = EXT_NONE;
            2'h1:    extKind = EXT_GATE;
            2'h2:    extKind = EXT_EDGE;
            default: extKind = EXT_LEVEL;
        endcase
    end

    // ************************************************************
    // External source
    // ************************************************************
    // Polarity bit 2 inverts the source; freeze blanks every trigger
    assign extLevel = extSources[rsrcReg] ^ modeReg[2];            // [R11]
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            extSrcReg  <= 1'b0;
            extPrevReg <= 1'b0;
        end else begin
            extSrcReg  <= extLevel;
            extPrevReg <= extSrcReg;
        end
    end
    assign extRise  = extSrcReg && !extPrevReg;
    assign gateOpen = extKind != EXT_GATE || debugFreeze || extSrcReg; // [R4] [R15]
    assign extClear = !debugFreeze &&                              // [R15]
                      ((extKind == EXT_EDGE  && extRise) ||        // [R5]
                       (extKind == EXT_LEVEL && extSrcReg));

    // ************************************************************
    // Prescaler
    // ************************************************************
    // Divide by 2^prescSel; one ref_clk-wide tick enable
    assign prescLimit   = 8'((`PRESC_COUNT_ONE << prescSel) - `PRESC_COUNT_ONE);
    assign clearScalers = wrCount || wrControl || extClear;        // [R7]
    assign counting     = runEnable && !stoppedReg && gateOpen;
    assign tick         = counting && prescReg == prescLimit;
    assign match        = countReg == periodReg;
    assign restart      = runEnable && !runPrevReg;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescReg <= `PRESC_COUNT_ZERO;                         // [R7]
        end else if (clearScalers || tick) begin
            prescReg <= `PRESC_COUNT_ZERO;                         // [R7]
        end else if (counting) begin
            prescReg <= prescReg + `PRESC_COUNT_ONE;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            countReg <= `COUNT_RESET;                              // [R6]
        end else if (wrCount) begin
            countReg <= regReq.wdata;                              // [R6]
        end else if (extClear) begin
            countReg <= `COUNT_RESET;                              // [R5]
        end else if (tick) begin
            countReg <= match ? `COUNT_RESET : countReg + 8'h01;   // [R1] [R2]
        end
    end

    // Stop after match in one-shot and monostable; external clear rearms
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stoppedReg <= 1'b0;
        end else if (restart || wrCount || extClear) begin
            stoppedReg <= 1'b0;                                    // [R10]
        end else if (tick && match && baseMode != BASE_FREE) begin
            stoppedReg <= 1'b1;                                    // [R8] [R10]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            runPrevReg <= 1'b0;
        end else begin
            runPrevReg <= runEnable;
        end
    end

    // ************************************************************
    // Postscaler
    // ************************************************************
    assign postHit = tick && match && postReg == postSel;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            postReg <= `POST_COUNT_ZERO;
        end else if (clearScalers || restart || postHit) begin
            postReg <= `POST_COUNT_ZERO;                           // [R3] [R7] [R9]
        end else if (tick && match) begin
            postReg <= postReg + 4'h1;                             // [R2]
        end
    end

    // Pulse width is one tick unless the next tick is also a hit: held until the next tick enable or until counting stops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseReg <= 1'b0;
        end else if (postHit) begin
            pulseReg <= 1'b1;                                      // [R3]
        end else if (tick || !counting) begin
            pulseReg <= 1'b0;
        end
    end
    assign postscaledPulse = pulseReg;                             // [R16]
    assign pwmFeed = '{count: countReg, match: match, tick: tick,
                       postscaled: pulseReg};                      // [R16]

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            controlReg <= `CTRL_RESET;
        end else if (wrControl) begin
            controlReg <= regReq.wdata;
        end else if (tick && match && baseMode == BASE_ONESHOT) begin
            controlReg[`CTRL_RUN_BIT] <= 1'b0;                     // [R8]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodReg <= `PERIOD_RESET;                            // [R6]
            clkSelReg <= '0;
            rsrcReg   <= '0;
            modeReg   <= '0;
            maskReg   <= 1'b0;
        end else if (regReq.wr) begin
            unique case (regReq.addr)
                `OFS_PERIOD:       periodReg <= regReq.wdata;
                `OFS_CLOCK_SELECT: clkSelReg <= regReq.wdata[`CLKSEL_W-1:0];
                `OFS_RESET_SOURCE: rsrcReg <= regReq.wdata[`RSRC_SEL_LSB +: `RSRC_W]; // [R11]
                `OFS_LIMIT:        modeReg <= regReq.wdata[`LIMIT_MODE_LSB +: `MODE_W]; // [R12]
                `OFS_IRQ_MASK:     maskReg <= regReq.wdata[`IRQ_BIT_MATCH];
                default:           ;
            endcase
        end
    end

    // Set beats the read-clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            statusReg <= 1'b0;
        end else if (postHit) begin
            statusReg <= 1'b1;                                     // [R17]
        end else if (regReq.rd && regReq.addr == `OFS_IRQ_STATUS) begin
            statusReg <= 1'b0;                                     // [R17]
        end
    end
    assign irq = statusReg && maskReg;                             // [R17]

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= `BYTE_ZERO;
        end else if (regReq.rd) begin
            unique case (regReq.addr)
                `OFS_TIMER_COUNT:  rdData <= countReg;             // [R6]
                `OFS_PERIOD:       rdData <= periodReg;            // [R6]
                `OFS_CONTROL:      rdData <= controlReg;
                `OFS_CLOCK_SELECT: rdData <= {5'h00, clkSelReg};
                `OFS_RESET_SOURCE: rdData <= {4'h0, rsrcReg};
                `OFS_LIMIT:        rdData <= {3'h0, modeReg};
                `OFS_IRQ_STATUS:   rdData <= {7'h00, statusReg};
                `OFS_IRQ_MASK:     rdData <= {7'h00, maskReg};
                default:           rdData <= `BYTE_ZERO;
            endcase
        end else begin
            rdData <= `BYTE_ZERO;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_period_reset_seen: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2]
        (tick && match && !wrCount && !extClear) |=> countReg == `COUNT_RESET)
        else $error("count not cleared after match");
    a_count_increment: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
        (tick && !match && !wrCount && !extClear) |=> countReg == $past(countReg) + 8'h01)
        else $error("count did not increment on tick");
    a_gate_hold_count: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
        (extKind == EXT_GATE && !extSrcReg && !debugFreeze && !wrCount) |=> $stable(countReg))
        else $error("count moved while gate closed");
    a_ext_clear_count: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
        (extClear && !wrCount) |=> countReg == `COUNT_RESET)
        else $error("external reset did not clear count");
    a_freeze_no_trig: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R15]
        debugFreeze |-> !extClear)
        else $error("trigger taken in debug freeze");
    a_scaler_clear_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
        (wrCount || wrControl) |=> prescReg == `PRESC_COUNT_ZERO && postReg == `POST_COUNT_ZERO)
        else $error("scalers not cleared on write");
    a_oneshot_stop_run: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
        (tick && match && baseMode == BASE_ONESHOT && !wrControl) |=> !runEnable && !tick)
        else $error("one-shot did not stop");
    a_mono_keep_run: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R10]
        (tick && match && baseMode == BASE_MONO && !wrControl && !extClear &&
         !wrCount && !restart)
        |=> runEnable && stoppedReg)
        else $error("monostable lost run enable or kept counting");
    a_pulse_from_hit: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
        $rose(pulseReg) |-> $past(postHit))
        else $error("pulse without postscaler hit");
    a_irq_flag_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R17]
        postHit |=> statusReg && (!maskReg || irq))
        else $error("flag not set on pulse");
    a_oneshot_post_rst: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
        restart |=> postReg == `POST_COUNT_ZERO)
        else $error("postscaler not reset on restart");
    a_control_keeps_cnt: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
        (wrControl && !tick && !extClear) |=> $stable(countReg))
        else $error("control write changed count");

endmodule
`default_nettype wire

// ==== testbench/period_match_timer_ext_model.sv ====
// Purpose: Far-side logic that drives the timer's external reset sources
// Assumes: Shares ref_clk with the timer; prescale 0 while triggers are sent
// Notes:   Every trigger keeps its level and its spacing, short requests are stretched
`default_nettype none
module period_match_timer_ext_model #(
    parameter int SRC_COUNT = 16
) (
    input  wire logic                 ref_clk,
    output logic [SRC_COUNT-1:0]      extSources
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Source lines
    // ****************************************
    initial begin
        extSources = '0;
    end

    // Raise one line for len ticks (three at least), then keep quiet before the next trigger
    task automatic pulse(input int sel, input int len);
        int n;
        n = (len < 3) ? 3 : len;
        @(posedge ref_clk);
        extSources[sel] <= 1'b1;
        repeat (n) @(posedge ref_clk);
        extSources[sel] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/period_match_timer_tb.sv ====
// Purpose: Self-checking bench for the period-match timer
// Assumes: Prescale 0 or 1 wherever exact tick counts are compared
// Notes:   Register port tasks plus an external trigger model
`include "period_match_timer_consts.svh"
`default_nettype none
module period_match_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import period_match_timer_pkg::*;

    logic        ref_clk;
    logic        reset_n;
    reg_req_t    regReq;
    logic [7:0]  rdData;
    logic [15:0] extSources;
    logic        debugFreeze;
    logic        postscaledPulse;
    pwm_feed_t   pwmFeed;
    logic        irq;
    int          n_mismatch;
    int          checks_done;
    int          cycles;

    period_match_timer #(.SRC_COUNT(16)) i_dut (
        .ref_clk         (ref_clk),
        .reset_n         (reset_n),
        .regReq          (regReq),
        .rdData          (rdData),
        .extSources      (extSources),
        .debugFreeze     (debugFreeze),
        .postscaledPulse (postscaledPulse),
        .pwmFeed         (pwmFeed),
        .irq             (irq)
    );

    period_match_timer_ext_model #(.SRC_COUNT(16)) i_ext (
        .ref_clk    (ref_clk),
        .extSources (extSources)
    );

    // ****************************************
    // Clock, timeout, verdict
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Whole run is well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        regReq.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        regReq.rd <= 1'b0;
        #1;
        chk(rdData, e);
    endtask

    task automatic waitlvl(input logic l, output int n);
        n = 0;
        while (postscaledPulse !== l && n < 400) begin
            cyc(1);
            n++;
        end
    endtask

    // Low gap and high width of one full output period
    task automatic measure(input int per, input int wid);
        int n;
        waitlvl(1'b1, n);
        waitlvl(1'b0, n);
        waitlvl(1'b1, n);
        chk(8'(n), 8'(per - wid));
        chk({7'h00, pwmFeed.postscaled}, 8'h01);
        waitlvl(1'b0, n);
        chk(8'(n), 8'(wid));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        regReq = '0;
        reset_n = 1'b0;
        debugFreeze = 1'b0;
        cycles = 0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(1);
        rdchk(`OFS_TIMER_COUNT, 8'h00);
        rdchk(`OFS_PERIOD, 8'hFF);
        rdchk(`OFS_CONTROL, 8'h00);
        wr(`OFS_PERIOD, 8'h2A);
        rdchk(`OFS_PERIOD, 8'h2A);
        wr(`OFS_TIMER_COUNT, 8'h11);
        wr(`OFS_CONTROL, 8'h00);
        rdchk(`OFS_TIMER_COUNT, 8'h11);
        wr(`OFS_RESET_SOURCE, 8'hFF);
        rdchk(`OFS_RESET_SOURCE, 8'h0F);
        wr(`OFS_LIMIT, 8'hFF);
        rdchk(`OFS_LIMIT, 8'h1F);
        wr(`OFS_CLOCK_SELECT, 8'hFF);
        rdchk(`OFS_CLOCK_SELECT, 8'h07);
        wr(`OFS_LIMIT, 8'h00);
        // Free running, then slower prescale and postscale
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_TIMER_COUNT, 8'h00);
        wr(`OFS_PERIOD, 8'h02);
        wr(`OFS_CONTROL, 8'h80);
        measure(3, 1);
        wr(`OFS_CONTROL, 8'h91);
        measure(12, 2);
        chk({7'h00, irq}, 8'h01);
        wr(`OFS_CONTROL, 8'h00);
        rdchk(`OFS_IRQ_STATUS, 8'h01);
        cyc(1);
        chk({7'h00, irq}, 8'h00);
        rdchk(`OFS_IRQ_STATUS, 8'h00);
        // One-shot, masked interrupt
        wr(`OFS_IRQ_MASK, 8'h00);
        wr(`OFS_LIMIT, 8'h08);
        wr(`OFS_PERIOD, 8'h03);
        wr(`OFS_CONTROL, 8'h80);
        cyc(20);
        rdchk(`OFS_CONTROL, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rdchk(`OFS_IRQ_STATUS, 8'h01);
        // Postscale 3 can never be reached after a restart
        wr(`OFS_CONTROL, 8'h83);
        cyc(20);
        rdchk(`OFS_IRQ_STATUS, 8'h00);
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_CONTROL, 8'h80);
        cyc(20);
        rdchk(`OFS_IRQ_STATUS, 8'h01);
        // Monostable with rising-edge restart from source 3
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_RESET_SOURCE, 8'h03);
        wr(`OFS_LIMIT, 8'h12);
        wr(`OFS_TIMER_COUNT, 8'h00);
        wr(`OFS_CONTROL, 8'h80);
        cyc(20);
        rdchk(`OFS_CONTROL, 8'h80);
        rdchk(`OFS_IRQ_STATUS, 8'h01);
        i_ext.pulse(4, 3);
        rdchk(`OFS_IRQ_STATUS, 8'h00);
        @(posedge ref_clk);
        debugFreeze <= 1'b1;
        i_ext.pulse(3, 3);
        rdchk(`OFS_IRQ_STATUS, 8'h00);
        @(posedge ref_clk);
        debugFreeze <= 1'b0;
        i_ext.pulse(3, 3);
        cyc(10);
        rdchk(`OFS_IRQ_STATUS, 8'h01);
        // Level reset holds the count at zero
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_LIMIT, 8'h03);
        wr(`OFS_RESET_SOURCE, 8'h05);
        wr(`OFS_PERIOD, 8'hFF);
        wr(`OFS_TIMER_COUNT, 8'h00);
        wr(`OFS_CONTROL, 8'h80);
        fork
            i_ext.pulse(5, 30);
            begin
                cyc(20);
                chk(pwmFeed.count, 8'h00);
            end
        join
        cyc(1);
        chk({7'h00, pwmFeed.count !== 8'h00}, 8'h01);
        // Gate on source 5: counts only while high
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_LIMIT, 8'h01);
        wr(`OFS_TIMER_COUNT, 8'h00);
        wr(`OFS_CONTROL, 8'h80);
        cyc(5);
        chk(pwmFeed.count, 8'h00);
        i_ext.pulse(5, 8);
        cyc(1);
        chk(pwmFeed.count, 8'h08);
        cyc(10);
        chk(pwmFeed.count, 8'h08);
        i_ext.pulse(5, 4);
        cyc(1);
        chk(pwmFeed.count, 8'h0C);
        end_of_test();
    end
endmodule
`default_nettype wire
